// file: ats_pkg.sv
// Shared constants for the task-file command engine and its host end.
package ats_pkg;
	// Task-file register offsets (data, error/feature ... command/status).
	localparam logic [2:0] TF_DATA = 3'h0;
	localparam logic [2:0] TF_ERRFEAT = 3'h1;
	localparam logic [2:0] TF_SCNT = 3'h2;
	localparam logic [2:0] TF_SNUM = 3'h3;
	localparam logic [2:0] TF_CYLL = 3'h4;
	localparam logic [2:0] TF_CYLH = 3'h5;
	localparam logic [2:0] TF_DRVHD = 3'h6;
	localparam logic [2:0] TF_CMDSTAT = 3'h7;
	// Command codes.
	localparam logic [7:0] CMD_READ_A = 8'h20;
	localparam logic [7:0] CMD_READ_B = 8'h21;
	localparam logic [7:0] CMD_VFY_A = 8'h40;
	localparam logic [7:0] CMD_VFY_B = 8'h41;
	localparam logic [7:0] CMD_SENSE = 8'h03;
	localparam logic [3:0] CMD_RECAL_HI = 4'h1;
	localparam logic [3:0] CMD_SEEK_HI = 4'h7;
	// Sector geometry.
	localparam logic [8:0] LAST_BYTE = 9'h1FF;
	localparam logic [8:0] MAX_SECTS = 9'h100;
	// Status byte bit positions.
	localparam int ST_BUSY = 7;
	localparam int ST_RDY = 6;
	localparam int ST_DSC = 4;
	localparam int ST_DATA_REQUEST_BIT = 3;
	localparam int ST_ERR = 0;
	// Drive/head register layout.
	localparam int DH_LBA = 6;
	localparam int DH_DRV = 4;
	localparam logic [7:0] DH_FIXED = 8'hA0;
	// Error register bits.
	localparam logic [7:0] ER_UNC = 8'h40;
	localparam logic [7:0] ER_IDNF = 8'h10;
	localparam logic [7:0] ER_ABRT = 8'h04;
	// Extended error codes.
	localparam logic [7:0] XE_NONE = 8'h00;
	localparam logic [7:0] XE_SELFTEST_OK = 8'h01;
	localparam logic [7:0] XE_MISC = 8'h09;
	localparam logic [7:0] XE_BAD_ADDR = 8'h21;
	localparam logic [7:0] XE_ADDR_OVF = 8'h2F;
	localparam logic [7:0] XE_IDNF_A = 8'h10;
	localparam logic [7:0] XE_IDNF_B = 8'h14;
	localparam logic [7:0] XE_VOLT_A = 8'h35;
	localparam logic [7:0] XE_VOLT_B = 8'h36;
	localparam logic [7:0] XE_UNCORR = 8'h11;
	localparam logic [7:0] XE_CORR = 8'h18;
	localparam logic [7:0] XE_DIAG_A = 8'h05;
	localparam logic [7:0] XE_DIAG_LO = 8'h30;
	localparam logic [7:0] XE_DIAG_HI = 8'h34;
	localparam logic [7:0] XE_DIAG_B = 8'h37;
	localparam logic [7:0] XE_DIAG_C = 8'h3E;
	localparam logic [7:0] XE_FMT_A = 8'h0C;
	localparam logic [7:0] XE_FMT_B = 8'h38;
	localparam logic [7:0] XE_FMT_C = 8'h3B;
	localparam logic [7:0] XE_FMT_D = 8'h3C;
	localparam logic [7:0] XE_FMT_E = 8'h3F;
	localparam logic [7:0] XE_SPARE = 8'h3A;
	localparam logic [7:0] XE_ABORT = 8'h1F;
	localparam logic [7:0] XE_WRFAIL = 8'h03;
	// Host-side Wishbone register map.
	localparam logic [7:0] WB_IRQ_STAT = 8'h20;
	localparam logic [7:0] WB_IRQ_MASK = 8'h24;
	localparam logic [7:0] WB_RD_CNT = 8'h28;
	localparam logic [2:0] WB_TF_TOP = 3'h0;
	localparam int IRQ_DEV = 0;
	localparam int IRQ_SECT = 1;
	localparam logic [9:0] SECT_BYTES = 10'h200;
endpackage

// file: ats_tf_if.sv
// Task-file link between the host controller and the device engine.
interface ats_tf_if;
	logic [2:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	logic intrq;
	modport dev (input addr, input wdata, input wr, input rd,
		output rdata, output intrq);
	modport hst (output addr, output wdata, output wr, output rd,
		input rdata, input intrq);
endinterface

// file: ats_dev.sv
// Device end: task file, command execution and sector buffer.
module ats_dev import ats_pkg::*; (
	input wire logic MCLK,
	input wire logic RST_B,
	ats_tf_if.dev tf,
	output logic MED_REQ,
	output logic MED_VERIFY,
	output logic MED_LBA,
	output logic [27:0] MED_ADDR,
	input wire logic MED_VALID,
	input wire logic [7:0] MED_DATA,
	input wire logic MED_DONE,
	input wire logic MED_ERR,
	input wire logic [7:0] MED_CODE,
	input wire logic [27:0] CAP_LBA,
	input wire logic [3:0] MAX_HEAD,
	input wire logic [7:0] SECT_PER_TRK,
	input wire logic [15:0] NUM_CYL
);
	typedef enum logic [2:0] {
		D_IDLE = 3'b001,
		D_FETCH = 3'b010,
		D_XFER = 3'b100
	} ats_dstate_t;

	typedef struct packed {
		ats_dstate_t st;
		logic [7:0] feat;
		logic [7:0] scnt;
		logic [7:0] snum;
		logic [7:0] cyll;
		logic [7:0] cylh;
		logic [7:0] dh;
		logic [7:0] err;
		logic [7:0] sense;
		logic busy;
		logic data_request_bit;
		logic errf;
		logic intrq;
		logic verify;
		logic med_req;
		logic [7:0] rdata;
		logic [8:0] left;
		logic [8:0] ptr;
		logic [511:0][7:0] sect_buf;
	} ats_dev_t;

	ats_dev_t q_ff;
	ats_dev_t nxt_q;

	// Address walk after a good sector, in either addressing mode.
	function automatic logic [31:0] adv_addr(input ats_dev_t s,
		input logic [3:0] mh, input logic [7:0] spt);
		logic [27:0] lba;
		logic [15:0] cyl;
		logic [3:0] hd;
		logic [7:0] sn;
		lba = {s.dh[3:0], s.cylh, s.cyll, s.snum};
		cyl = {s.cylh, s.cyll};
		hd = s.dh[3:0];
		sn = s.snum;
		if (s.dh[DH_LBA]) begin
			lba = lba + 28'h0000001;
			adv_addr = {4'h0, lba};
		end else begin
			if (sn >= spt) begin
				sn = 8'h01;
				if (hd >= mh) begin
					hd = 4'h0;
					cyl = cyl + 16'h0001;
				end else begin
					hd = hd + 4'h1;
				end
			end else begin
				sn = sn + 8'h01;
			end
			adv_addr = {4'h0, hd, cyl, sn};
		end
	endfunction

	// Seek range check; answers the extended code, XE_NONE when in range.
	function automatic logic [7:0] range_code(input ats_dev_t s,
		input logic [27:0] cap, input logic [3:0] mh,
		input logic [7:0] spt, input logic [15:0] ncyl);
		range_code = XE_NONE;
		if (s.dh[DH_LBA]) begin
			if ({s.dh[3:0], s.cylh, s.cyll, s.snum} >= cap) begin
				range_code = XE_ADDR_OVF;
			end
		end else if (s.dh[3:0] > mh || s.snum == 8'h00 ||
			s.snum > spt || {s.cylh, s.cyll} >= ncyl) begin
			range_code = XE_BAD_ADDR;
		end
	endfunction

	always_comb begin
		logic [31:0] na;
		logic [7:0] rc;
		nxt_q = q_ff;
		na = adv_addr(q_ff, MAX_HEAD, SECT_PER_TRK);
		rc = range_code(q_ff, CAP_LBA, MAX_HEAD, SECT_PER_TRK, NUM_CYL);
		if (tf.rd) begin
			case (tf.addr)
				TF_DATA: begin
					nxt_q.rdata = q_ff.data_request_bit ?
						q_ff.sect_buf[q_ff.ptr] : 8'h00;
				end
				TF_ERRFEAT: nxt_q.rdata = q_ff.err;
				TF_SCNT: nxt_q.rdata = q_ff.scnt;
				TF_SNUM: nxt_q.rdata = q_ff.snum;
				TF_CYLL: nxt_q.rdata = q_ff.cyll;
				TF_CYLH: nxt_q.rdata = q_ff.cylh;
				TF_DRVHD: nxt_q.rdata = q_ff.dh | DH_FIXED;
				TF_CMDSTAT: begin
					nxt_q.rdata = 8'h00;
					nxt_q.rdata[ST_BUSY] = q_ff.busy;
					nxt_q.rdata[ST_RDY] = ~q_ff.busy;
					nxt_q.rdata[ST_DSC] = 1'b1;
					nxt_q.rdata[ST_DATA_REQUEST_BIT] = q_ff.data_request_bit;
					nxt_q.rdata[ST_ERR] = q_ff.errf;
					// Reading status acknowledges the interrupt.
					nxt_q.intrq = 1'b0;
				end
				default: nxt_q.rdata = 8'h00;
			endcase
		end
		// Writes while busy are dropped; the engine owns the task file then.
		if (tf.wr && !q_ff.busy) begin
			case (tf.addr)
				TF_ERRFEAT: nxt_q.feat = tf.wdata;
				TF_SCNT: nxt_q.scnt = tf.wdata;
				TF_SNUM: nxt_q.snum = tf.wdata;
				TF_CYLL: nxt_q.cyll = tf.wdata;
				TF_CYLH: nxt_q.cylh = tf.wdata;
				TF_DRVHD: nxt_q.dh = tf.wdata;
				TF_CMDSTAT: begin
					nxt_q.errf = 1'b0;
					nxt_q.err = 8'h00;
					nxt_q.data_request_bit = 1'b0;
					nxt_q.ptr = 9'h000;
					nxt_q.intrq = 1'b0;
					nxt_q.st = D_IDLE;
					if (tf.wdata == CMD_READ_A || tf.wdata == CMD_READ_B ||
						tf.wdata == CMD_VFY_A || tf.wdata == CMD_VFY_B) begin
						nxt_q.left = (q_ff.scnt == 8'h00) ? MAX_SECTS :
							{1'b0, q_ff.scnt};
						nxt_q.verify = tf.wdata[6];
						nxt_q.busy = 1'b1;
						nxt_q.med_req = 1'b1;
						nxt_q.st = D_FETCH;
					end else if (tf.wdata == CMD_SENSE) begin
						nxt_q.err = q_ff.sense;
						nxt_q.intrq = 1'b1;
					end else if (tf.wdata[7:4] == CMD_RECAL_HI) begin
						nxt_q.sense = XE_NONE;
						nxt_q.intrq = 1'b1;
					end else if (tf.wdata[7:4] == CMD_SEEK_HI) begin
						nxt_q.sense = rc;
						nxt_q.errf = (rc != XE_NONE);
						nxt_q.err = (rc != XE_NONE) ? ER_IDNF : 8'h00;
						nxt_q.intrq = 1'b1;
					end else begin
						nxt_q.sense = XE_ABORT;
						nxt_q.errf = 1'b1;
						nxt_q.err = ER_ABRT;
						nxt_q.intrq = 1'b1;
					end
				end
				default: ;
			endcase
		end
		case (q_ff.st)
			D_FETCH: begin
				if (MED_VALID && q_ff.med_req) begin
					nxt_q.sect_buf[q_ff.ptr] = MED_DATA;
					nxt_q.ptr = q_ff.ptr + 9'h001;
				end
				if (MED_DONE && q_ff.med_req) begin
					nxt_q.med_req = 1'b0;
					nxt_q.ptr = 9'h000;
					nxt_q.sense = MED_CODE;
					if (MED_ERR) begin
						// Address stays on the failing sector.
						nxt_q.busy = 1'b0;
						nxt_q.errf = 1'b1;
						nxt_q.err = ER_UNC;
						nxt_q.intrq = 1'b1;
						nxt_q.scnt = q_ff.left[7:0];
						nxt_q.st = D_IDLE;
					end else if (!q_ff.verify) begin
						nxt_q.busy = 1'b0;
						nxt_q.data_request_bit = 1'b1;
						nxt_q.intrq = 1'b1;
						nxt_q.st = D_XFER;
					end else if (q_ff.left == 9'h001) begin
						nxt_q.busy = 1'b0;
						nxt_q.intrq = 1'b1;
						nxt_q.scnt = 8'h00;
						nxt_q.st = D_IDLE;
					end else begin
						nxt_q.left = q_ff.left - 9'h001;
						nxt_q.scnt = q_ff.scnt - 8'h01;
						{nxt_q.dh[3:0], nxt_q.cylh, nxt_q.cyll, nxt_q.snum} =
							na[27:0];
						nxt_q.med_req = 1'b1;
					end
				end
			end
			D_XFER: begin
				if (tf.rd && tf.addr == TF_DATA) begin
					nxt_q.ptr = q_ff.ptr + 9'h001;
					if (q_ff.ptr == LAST_BYTE) begin
						nxt_q.data_request_bit = 1'b0;
						nxt_q.ptr = 9'h000;
						if (q_ff.left == 9'h001) begin
							nxt_q.scnt = 8'h00;
							nxt_q.st = D_IDLE;
						end else begin
							nxt_q.left = q_ff.left - 9'h001;
							nxt_q.scnt = q_ff.scnt - 8'h01;
							{nxt_q.dh[3:0], nxt_q.cylh, nxt_q.cyll,
								nxt_q.snum} = na[27:0];
							nxt_q.busy = 1'b1;
							nxt_q.med_req = 1'b1;
							nxt_q.st = D_FETCH;
						end
					end
				end
			end
			D_IDLE: ;
			default: nxt_q.st = D_IDLE;
		endcase
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			q_ff <= '0;
			q_ff.st <= D_IDLE;
			q_ff.dh <= DH_FIXED;
		end else begin
			q_ff <= nxt_q;
		end
	end

	assign tf.rdata = q_ff.rdata;
	assign tf.intrq = q_ff.intrq;
	assign MED_REQ = q_ff.med_req;
	assign MED_VERIFY = q_ff.verify;
	assign MED_LBA = q_ff.dh[DH_LBA];
	assign MED_ADDR = {q_ff.dh[3:0], q_ff.cylh, q_ff.cyll, q_ff.snum};
endmodule

// file: ats_host.sv
// Host end: Wishbone slave that drives the task file for software.
module ats_host import ats_pkg::*; (
	input wire logic MCLK,
	input wire logic RST_B,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	input wire logic WB_WE_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	output logic WB_ACK_O,
	output logic IRQ,
	ats_tf_if.hst tf
);
	typedef enum logic [3:0] {
		H_IDLE = 4'b0001,
		H_RD = 4'b0010,
		H_CAP = 4'b0100,
		H_ACK = 4'b1000
	} ats_hstate_t;

	typedef struct packed {
		ats_hstate_t st;
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
		logic [31:0] dat;
		logic ack;
		logic irq;
		logic intrq_d;
		logic [1:0] stat;
		logic [1:0] mask;
		logic [9:0] cnt;
	} ats_host_t;

	ats_host_t q_ff;
	ats_host_t nxt_q;

	always_comb begin
		logic req;
		logic is_tf;
		logic [1:0] ev;
		nxt_q = q_ff;
		req = WB_CYC_I && WB_STB_I;
		is_tf = (WB_ADR_I[7:5] == WB_TF_TOP);
		ev = 2'b00;
		nxt_q.wr = 1'b0;
		nxt_q.rd = 1'b0;
		nxt_q.ack = 1'b0;
		nxt_q.intrq_d = tf.intrq;
		ev[IRQ_DEV] = tf.intrq && !q_ff.intrq_d;
		case (q_ff.st)
			H_IDLE: begin
				if (req) begin
					nxt_q.addr = WB_ADR_I[4:2];
					nxt_q.dat = 32'h0000_0000;
					if (is_tf && WB_WE_I) begin
						nxt_q.wdata = WB_DAT_I[7:0];
						nxt_q.wr = WB_SEL_I[0];
						nxt_q.ack = 1'b1;
						nxt_q.st = H_ACK;
					end else if (is_tf) begin
						nxt_q.rd = 1'b1;
						nxt_q.st = H_RD;
					end else begin
						nxt_q.ack = 1'b1;
						nxt_q.st = H_ACK;
						if (WB_WE_I && WB_SEL_I[0]) begin
							if (WB_ADR_I == WB_IRQ_STAT) begin
								nxt_q.stat = q_ff.stat & ~WB_DAT_I[1:0];
							end else if (WB_ADR_I == WB_IRQ_MASK) begin
								nxt_q.mask = WB_DAT_I[1:0];
							end else if (WB_ADR_I == WB_RD_CNT) begin
								nxt_q.cnt = 10'h000;
							end
						end else if (!WB_WE_I) begin
							if (WB_ADR_I == WB_IRQ_STAT) begin
								nxt_q.dat = {30'h0, q_ff.stat};
							end else if (WB_ADR_I == WB_IRQ_MASK) begin
								nxt_q.dat = {30'h0, q_ff.mask};
							end else if (WB_ADR_I == WB_RD_CNT) begin
								nxt_q.dat = {22'h0, q_ff.cnt};
							end
						end
					end
				end
			end
			H_RD: nxt_q.st = H_CAP;
			H_CAP: begin
				nxt_q.dat = {24'h0, tf.rdata};
				nxt_q.ack = 1'b1;
				nxt_q.st = H_ACK;
				if (q_ff.addr == TF_DATA) begin
					// Counts toward one whole sector per data request.
					nxt_q.cnt = q_ff.cnt + 10'h001;
					if (q_ff.cnt + 10'h001 == SECT_BYTES) begin
						ev[IRQ_SECT] = 1'b1;
						nxt_q.cnt = 10'h000;
					end
				end
			end
			H_ACK: nxt_q.st = H_IDLE;
			default: nxt_q.st = H_IDLE;
		endcase
		// A new event wins over a clear in the same cycle.
		nxt_q.stat = nxt_q.stat | ev;
		nxt_q.irq = |(nxt_q.stat & nxt_q.mask);
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			q_ff <= '0;
			q_ff.st <= H_IDLE;
		end else begin
			q_ff <= nxt_q;
		end
	end

	assign WB_DAT_O = q_ff.dat;
	assign WB_ACK_O = q_ff.ack;
	assign IRQ = q_ff.irq;
	assign tf.addr = q_ff.addr;
	assign tf.wdata = q_ff.wdata;
	assign tf.wr = q_ff.wr;
	assign tf.rd = q_ff.rd;
endmodule

// file: ats_tf_assertions.sv
// Concurrent checks on the task-file link between host and device ends.
module ats_tf_assertions import ats_pkg::*; (
	input wire logic MCLK,
	input wire logic RST_B,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic intrq
);
	logic vfy_ff;
	logic cmd_wr;
	logic st_rd;
	assign cmd_wr = wr && addr == TF_CMDSTAT;
	assign st_rd = rd && addr == TF_CMDSTAT;
	// Software never issues an opcode while busy, so the last one written runs.
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			vfy_ff <= 1'b0;
		end else if (cmd_wr) begin
			vfy_ff <= wdata[7:1] == 7'h20;
		end
	end
	default clocking @(posedge MCLK);
	endclocking
	default disable iff (!RST_B);
	a_strobe_excl: assert property (!(wr && rd))
		else $error("read and write strobes together");
	a_wr_pulse: assert property (wr |=> !wr)
		else $error("write strobe longer than one cycle");
	a_rdata_hold: assert property (!rd |=> $stable(rdata))
		else $error("read data moved without a read");
	a_busy_req_excl: assert property (
		st_rd |=> !(rdata[ST_BUSY] && rdata[ST_DATA_REQUEST_BIT]))
		else $error("data request shown while busy");
	a_ready_inv: assert property (
		st_rd |=> rdata[ST_RDY] != rdata[ST_BUSY])
		else $error("ready bit not the inverse of busy");
	a_dh_fixed: assert property (
		rd && addr == TF_DRVHD |=> rdata[7] && rdata[5])
		else $error("drive/head fixed bits not one");
	a_vfy_no_req: assert property (
		st_rd && vfy_ff |=> !rdata[ST_DATA_REQUEST_BIT])
		else $error("data request during verify");
	a_recal_done: assert property (
		cmd_wr && wdata[7:4] == CMD_RECAL_HI |-> ##[1:4] intrq)
		else $error("recalibrate gave no interrupt");
	a_seek_done: assert property (
		cmd_wr && wdata[7:4] == CMD_SEEK_HI |-> ##[1:4] intrq)
		else $error("seek gave no interrupt");
	a_sense_done: assert property (
		cmd_wr && wdata == CMD_SENSE |-> ##[1:4] intrq)
		else $error("request sense gave no interrupt");
	c_read: cover property (cmd_wr && wdata == CMD_READ_A);
	c_data_req: cover property (st_rd ##1 rdata[ST_DATA_REQUEST_BIT]);
	c_err: cover property (st_rd ##1 rdata[ST_ERR]);
endmodule

// file: ata_sector_read_verify_cmds_tb.sv
// Bench: software bus on the host end, media model on the device end.
module ata_sector_read_verify_cmds_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ats_pkg::*;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic we = 1'b0;
	logic [3:0] sel = 4'h0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic ack;
	logic irq;
	logic i0;
	logic med_req;
	logic med_vfy;
	logic med_lba;
	logic [27:0] med_addr;
	logic med_valid = 1'b0;
	logic [7:0] med_data = 8'h00;
	logic med_done = 1'b0;
	logic med_err = 1'b0;
	logic [7:0] med_code = 8'h00;
	logic [7:0] mb;
	logic [27:0] cap = 28'h0100000;
	logic [3:0] mh = 4'h7;
	logic [7:0] spt = 8'h20;
	logic [15:0] ncyl = 16'h0400;
	logic [31:0] rng = 32'hFB89;
	logic [7:0] ecode = 8'h00;
	int err_at = -1;
	int msec = 0;
	int error_cnt = 0;
	int checks_done = 0;
	logic [63:0] wq[$];
	logic [27:0] aq[$];
	logic [7:0] dq[$];
	always #12.5 mclk = ~mclk;
	ats_tf_if ats_tf_if_i();
	ats_host ats_host_i(.MCLK(mclk), .RST_B(rst_b), .WB_ADR_I(adr),
		.WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_WE_I(we), .WB_SEL_I(sel),
		.WB_CYC_I(cyc), .WB_STB_I(stb), .WB_ACK_O(ack), .IRQ(irq),
		.tf(ats_tf_if_i));
	ats_dev ats_dev_i(.MCLK(mclk), .RST_B(rst_b), .tf(ats_tf_if_i),
		.MED_REQ(med_req), .MED_VERIFY(med_vfy), .MED_LBA(med_lba),
		.MED_ADDR(med_addr), .MED_VALID(med_valid), .MED_DATA(med_data),
		.MED_DONE(med_done), .MED_ERR(med_err), .MED_CODE(med_code),
		.CAP_LBA(cap), .MAX_HEAD(mh), .SECT_PER_TRK(spt), .NUM_CYL(ncyl));
	ats_tf_assertions ats_tf_assertions_i(.MCLK(mclk), .RST_B(rst_b),
		.addr(ats_tf_if_i.addr), .wdata(ats_tf_if_i.wdata),
		.wr(ats_tf_if_i.wr), .rd(ats_tf_if_i.rd),
		.rdata(ats_tf_if_i.rdata), .intrq(ats_tf_if_i.intrq));
	function automatic logic [7:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng[7:0];
	endfunction
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		checks_done++;
		if (s !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic end_of_test();
		if (error_cnt == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// For a read, d is the expected data and m the bits compared.
	task automatic wb(input logic [7:0] a, input logic w,
		input logic [31:0] d, input logic [31:0] m);
		if (!w) begin
			wq.push_back({m, d});
		end
		adr <= a;
		we <= w;
		wdat <= w ? d : 32'h0;
		sel <= 4'hF;
		cyc <= 1'b1;
		stb <= 1'b1;
		do begin
			@(posedge mclk);
		end while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic wtf(input logic [2:0] o, input logic [7:0] v);
		wb({3'h0, o, 2'h0}, 1'b1, {24'h0, v}, 32'h0);
	endtask
	task automatic rtf(input logic [2:0] o, input logic [7:0] e,
		input logic [7:0] m);
		wb({3'h0, o, 2'h0}, 1'b0, {24'h0, e}, {24'h0, m});
	endtask
	task automatic wirq();
		int n;
		n = 0;
		while (ats_tf_if_i.intrq !== 1'b1 && n < 5000) begin
			@(posedge mclk);
			n++;
		end
		chk("intrq", 32'h1, {31'h0, ats_tf_if_i.intrq});
	endtask
	task automatic run(input logic [7:0] c, input logic [7:0] st,
		input logic [7:0] m);
		wtf(TF_CMDSTAT, c);
		wirq();
		rtf(TF_CMDSTAT, st, m);
	endtask
	task automatic sense(input logic [7:0] e);
		run(CMD_SENSE, 8'h50, 8'hC8);
		rtf(TF_ERRFEAT, e, 8'hFF);
	endtask
	// Loads a logical start address and notes the n sector addresses due.
	task automatic lba(input logic [27:0] l, input logic [7:0] c, input int n);
		wtf(TF_SCNT, c);
		wtf(TF_SNUM, l[7:0]);
		wtf(TF_CYLL, l[15:8]);
		wtf(TF_CYLH, l[23:16]);
		wtf(TF_DRVHD, {4'hE, l[27:24]});
		for (int i = 0; i < n; i++) begin
			aq.push_back(l + 28'(i));
		end
	endtask
	always @(posedge mclk) begin
		if (ack === 1'b1 && !we) begin
			chk("wb read", wq[0][31:0] & wq[0][63:32], rdat & wq[0][63:32]);
			void'(wq.pop_front());
		end
	end
	// Media model: a verify sector carries no bytes, only its completion.
	initial begin
		forever begin
			@(posedge mclk);
			if (med_req === 1'b1) begin
				chk("media addr", {4'h0, aq.pop_front()},
					{4'h0, med_addr});
				chk("media lba", 32'h1, {31'h0, med_lba});
				if (med_vfy === 1'b0) begin
					for (int i = 0; i < 512; i++) begin
						mb = rnd();
						dq.push_back(mb);
						med_valid <= 1'b1;
						med_data <= mb;
						@(posedge mclk);
					end
					med_valid <= 1'b0;
					med_data <= ~mb;
				end
				med_done <= 1'b1;
				med_err <= msec == err_at;
				med_code <= msec == err_at ? ecode : XE_NONE;
				msec++;
				@(posedge mclk);
				med_done <= 1'b0;
				med_err <= 1'b0;
			end
		end
	end
	// Roughly eight times the expected run before a hang is declared.
	initial begin
		#1500000;
		error_cnt++;
		end_of_test();
	end
	initial begin
		repeat (5) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		rtf(TF_DRVHD, DH_FIXED, 8'hFF);
		wb(8'hFC, 1'b1, 32'h5A, 32'h0);
		wb(8'hFC, 1'b0, 32'h0, 32'hFFFFFFFF);
		lba(28'h00123FF, 8'h02, 2);
		wtf(TF_CMDSTAT, CMD_READ_A);
		repeat (2) begin
			wirq();
			rtf(TF_CMDSTAT, 8'h58, 8'hFF);
			repeat (512) rtf(TF_DATA, dq.pop_front(), 8'hFF);
		end
		rtf(TF_CMDSTAT, 8'h50, 8'hFF);
		rtf(TF_SCNT, 8'h00, 8'hFF);
		rtf(TF_SNUM, 8'h00, 8'hFF);
		rtf(TF_CYLL, 8'h24, 8'hFF);
		wb(WB_IRQ_STAT, 1'b0, 32'h3, 32'h3);
		wb(WB_IRQ_MASK, 1'b1, 32'h0, 32'h0);
		repeat (2) @(posedge mclk);
		#1 i0 = irq;
		@(posedge mclk);
		wb(WB_IRQ_MASK, 1'b1, 32'h3, 32'h0);
		repeat (2) @(posedge mclk);
		#1 chk("irq masked", 32'h0, {31'h0, i0});
		chk("irq mask", 32'h1, {31'h0, irq});
		@(posedge mclk);
		wb(WB_IRQ_STAT, 1'b1, 32'h3, 32'h0);
		wb(WB_IRQ_STAT, 1'b0, 32'h0, 32'h3);
		lba(28'h0000F80, 8'h00, 256);
		wtf(TF_CMDSTAT, CMD_VFY_B);
		rtf(TF_CMDSTAT, 8'h80, 8'h80);
		wirq();
		chk("sectors left", 32'h0, aq.size());
		rtf(TF_CMDSTAT, 8'h50, 8'hFF);
		for (int k = 0; k < 2; k++) begin
			msec = 0;
			err_at = k * 2;
			ecode = k ? XE_IDNF_B : XE_UNCORR;
			lba(28'h0002000, 8'h02 + 8'(k * 3), k * 2 + 1);
			run(k ? CMD_VFY_A : CMD_READ_B, 8'h51, 8'hFF);
			rtf(TF_SCNT, 8'h02 + 8'(k), 8'hFF);
			rtf(TF_SNUM, 8'(k * 2), 8'hFF);
			rtf(TF_ERRFEAT, ER_UNC, 8'hFF);
			sense(ecode);
			dq.delete();
		end
		err_at = -1;
		for (int k = 0; k < 16; k++) begin
			run({CMD_RECAL_HI, 4'(k)}, 8'h50, 8'hFF);
		end
		sense(XE_NONE);
		lba(28'h00000FF, 8'h01, 0);
		run({CMD_SEEK_HI, 4'(rnd())}, 8'h50, 8'hFF);
		lba(cap, 8'h01, 0);
		run({CMD_SEEK_HI, 4'(rnd())}, 8'h51, 8'hFF);
		sense(XE_ADDR_OVF);
		wtf(TF_DRVHD, 8'hA8);
		wtf(TF_CYLH, 8'h00);
		wtf(TF_CYLL, 8'h00);
		wtf(TF_SNUM, 8'h01);
		run({CMD_SEEK_HI, 4'(rnd())}, 8'h51, 8'hFF);
		sense(XE_BAD_ADDR);
		run(8'h00, 8'h51, 8'hFF);
		rtf(TF_ERRFEAT, ER_ABRT, 8'hFF);
		sense(XE_ABORT);
		end_of_test();
	end
endmodule
